// file: cpr_pkg.sv
package cpr_pkg;
   // Reset values
   localparam logic [15:0] CPR_SP_RST = 16'h00FF;
   localparam logic [7:0] CPR_H_RST = 8'h00;
   localparam logic [7:0] CPR_FLAGS_RST = 8'h68;
   // Reset vector location (high byte first, then low byte)
   localparam logic [15:0] CPR_VEC_ADDR = 16'hFFFE;
   // Condition flags bit positions
   localparam int CPR_FB_V = 7;
   localparam int CPR_FB_H = 4;
   localparam int CPR_FB_I = 3;
   localparam int CPR_FB_N = 2;
   localparam int CPR_FB_Z = 1;
   localparam int CPR_FB_C = 0;
   // Bits that always read as one
   localparam logic [7:0] CPR_FLAGS_ONES = 8'h60;
   // Upper address byte implied for direct page accesses
   localparam logic [7:0] CPR_DIR_PAGE = 8'h00;

   // Operations issued by the sequencer, one per cycle
   typedef enum logic [4:0] {
      CPR_OP_NOP, CPR_OP_LDA, CPR_OP_LDX, CPR_OP_LDHX, CPR_OP_TAX, CPR_OP_TXA,
      CPR_OP_CLRX, CPR_OP_INCX, CPR_OP_DECX, CPR_OP_COMX, CPR_OP_NEGX,
      CPR_OP_LSLX, CPR_OP_LSRX, CPR_OP_ROLX, CPR_OP_RORX,
      CPR_OP_SP_ADJ, CPR_OP_SP_LOW, CPR_OP_PUSH, CPR_OP_PULL,
      CPR_OP_JUMP, CPR_OP_BRANCH, CPR_OP_INT_ENTER, CPR_OP_MASK_CLR, CPR_OP_SEI,
      CPR_OP_FLAGS, CPR_OP_DIR, CPR_OP_IDX
   } cpr_op_e;

   // Register that a push reads or a pull writes
   typedef enum logic [2:0] {
      CPR_SEL_ACC, CPR_SEL_X, CPR_SEL_H, CPR_SEL_FLAGS, CPR_SEL_PCL, CPR_SEL_PCH
   } cpr_sel_e;
endpackage

// file: cpr_stk_if.sv
interface cpr_stk_if;
   import cpr_pkg::*;
   logic push; // Byte pushed this cycle
   logic pull; // Byte pulled this cycle
   logic adj; // Add signed immediate
   logic low_rst; // Reset low byte only
   logic [7:0] imm; // Signed immediate
   logic [15:0] sp; // Current stack pointer
   logic [15:0] addr; // Address of this cycle's stack access
   modport ctl (output push, output pull, output adj, output low_rst, output imm,
                input sp, input addr);
   modport unit (input push, input pull, input adj, input low_rst, input imm,
                 output sp, output addr);
endinterface

// file: cpr_stack.sv
module cpr_stack
   import cpr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   cpr_stk_if.unit stk
);
   logic [15:0] sp_q; // Stack pointer
   logic [15:0] sp_d; // Next stack pointer
   logic [15:0] sp_inc; // Pointer plus one
   logic [15:0] sext_imm; // Sign-extended immediate

   assign sp_inc = sp_q + 16'h0001;
   assign sext_imm = {{8{stk.imm[7]}}, stk.imm}; // RULE_07
   // Push writes the free slot; pull reads the slot above it
   assign stk.addr = stk.pull ? sp_inc : sp_q; // RULE_05
   assign stk.sp = sp_q;

   // Pointer update selection
   always_comb
   begin
      sp_d = sp_q;
      if (stk.push)
         sp_d = sp_q - 16'h0001; // RULE_19
      else if (stk.pull)
         sp_d = sp_inc; // RULE_19
      else if (stk.adj)
         sp_d = sp_q + sext_imm; // RULE_07
      else if (stk.low_rst)
         sp_d = {sp_q[15:8], CPR_SP_RST[7:0]}; // RULE_08
   end

   // Stack pointer register
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         sp_q <= CPR_SP_RST; // RULE_06
      else
         sp_q <= sp_d;
   end
endmodule

// file: cpr_regs.sv
// Functional notes
// (RULE_01) 8-bit accumulator, untouched by reset
// (RULE_02) Index pair H:X used as 16 bits
// (RULE_03) Reset clears H, keeps X
// (RULE_04) X supports unary ops and transfers
// (RULE_05) Stack pointer addresses next free location
// (RULE_06) Reset loads stack pointer with 00FF
// (RULE_07) Adjust adds sign-extended immediate to pointer
// (RULE_08) Low reset op changes low byte only
// (RULE_09) Calls and interrupts push return state
// (RULE_10) Program counter increments on every fetch
// (RULE_11) Change-of-flow loads program counter instead
// (RULE_12) Reset loads program counter from vector
// (RULE_13) Flags bits 6 and 5 read one
// (RULE_14) Registers are not memory mapped
// (RULE_15) Direct addressing uses page zero only
// (RULE_16) Flags layout V,-,-,H,I,N,Z,C
// (RULE_17) Interrupt entry sets mask after stacking
// (RULE_18) No interrupt right after mask clear
// (RULE_19) Push decrements after, pull increments before
module cpr_regs
   import cpr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire cpr_op_e op,
   input wire cpr_sel_e sel,
   input wire logic [15:0] din,
   input wire logic [15:0] reset_vector,
   input wire logic [7:0] flags_in,
   input wire logic fetch,
   input wire logic instr_end,
   output logic [7:0] acc_q,
   output logic [7:0] h_q,
   output logic [7:0] x_q,
   output logic [15:0] sp_q,
   output logic [15:0] pc_q,
   output logic [7:0] flags_q,
   output logic [15:0] ea_q,
   output logic [15:0] mem_addr_q,
   output logic [7:0] mem_wdata_q,
   output logic mem_we_q,
   output logic int_allow_q
);
   cpr_stk_if stk ();

   // Unary X operation: returns carry out and result
   function automatic logic [8:0] x_unary(cpr_op_e o, logic [7:0] x, logic c);
      logic [8:0] r;
      r = {c, x};
      unique case (o)
         CPR_OP_CLRX: r = {c, 8'h00};
         CPR_OP_INCX: r = {c, x + 8'h01};
         CPR_OP_DECX: r = {c, x - 8'h01};
         CPR_OP_COMX: r = {1'b1, ~x};
         CPR_OP_NEGX: r = {(x != 8'h00), 8'h00 - x};
         CPR_OP_LSLX: r = {x[7], x[6:0], 1'b0};
         CPR_OP_LSRX: r = {x[0], 1'b0, x[7:1]};
         CPR_OP_ROLX: r = {x[7], x[6:0], c};
         CPR_OP_RORX: r = {x[0], c, x[7:1]};
         default: r = {c, x};
      endcase
      return r;
   endfunction

   logic inhibit_q; // Interrupt blocked until next boundary
   logic [7:0] x_d; // Next X
   logic [8:0] xu; // Unary result with carry
   logic x_unary_op; // Op is a unary X op
   logic [15:0] hx; // Full index value
   logic [15:0] pc_inc; // Sequential next address
   logic [15:0] pc_rel; // Branch target
   logic [7:0] push_byte; // Byte chosen for a push
   logic [7:0] flags_d; // Next flags
   logic [15:0] pc_d; // Next program counter
   logic mask_clr; // Op clears the interrupt mask

   assign hx = {h_q, x_q}; // RULE_02
   assign pc_inc = pc_q + 16'h0001;
   assign pc_rel = pc_q + {{8{din[7]}}, din[7:0]};
   assign x_unary_op = op inside {CPR_OP_CLRX, CPR_OP_INCX, CPR_OP_DECX, CPR_OP_COMX,
                                  CPR_OP_NEGX, CPR_OP_LSLX, CPR_OP_LSRX, CPR_OP_ROLX,
                                  CPR_OP_RORX};
   assign xu = x_unary(op, x_q, flags_q[CPR_FB_C]); // RULE_04
   assign mask_clr = (op == CPR_OP_MASK_CLR) ||
                     (op == CPR_OP_FLAGS && !din[CPR_FB_I] && flags_q[CPR_FB_I]);

   // Stack unit commands
   assign stk.push = (op == CPR_OP_PUSH); // RULE_09
   assign stk.pull = (op == CPR_OP_PULL);
   assign stk.adj = (op == CPR_OP_SP_ADJ); // RULE_07
   assign stk.low_rst = (op == CPR_OP_SP_LOW); // RULE_08
   assign stk.imm = din[7:0];
   assign sp_q = stk.sp;

   cpr_stack u_stack (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .stk(stk)
   );

   // Byte source for pushes: return address or CPU registers
   always_comb
   begin
      unique case (sel)
         CPR_SEL_ACC: push_byte = acc_q;
         CPR_SEL_X: push_byte = x_q;
         CPR_SEL_H: push_byte = h_q;
         CPR_SEL_FLAGS: push_byte = flags_q;
         CPR_SEL_PCL: push_byte = pc_q[7:0];
         CPR_SEL_PCH: push_byte = pc_q[15:8];
         default: push_byte = 8'h00;
      endcase
   end

   // Next X value
   always_comb
   begin
      x_d = x_q;
      if (x_unary_op)
         x_d = xu[7:0]; // RULE_04
      else if (op == CPR_OP_LDX || op == CPR_OP_LDHX)
         x_d = din[7:0];
      else if (op == CPR_OP_TAX)
         x_d = acc_q; // RULE_04
      else if (op == CPR_OP_PULL && sel == CPR_SEL_X)
         x_d = din[7:0];
   end

   // Next program counter; change-of-flow beats sequential fetch
   always_comb
   begin
      pc_d = pc_q;
      if (op == CPR_OP_JUMP || op == CPR_OP_INT_ENTER)
         pc_d = din; // RULE_11
      else if (op == CPR_OP_BRANCH)
         pc_d = pc_rel; // RULE_11
      else if (op == CPR_OP_PULL && sel == CPR_SEL_PCL)
         pc_d = {pc_q[15:8], din[7:0]}; // RULE_11
      else if (op == CPR_OP_PULL && sel == CPR_SEL_PCH)
         pc_d = {din[7:0], pc_q[7:0]};
      else if (fetch)
         pc_d = pc_inc; // RULE_10
   end

   // Next flags; fixed ones always forced
   always_comb
   begin
      flags_d = flags_q;
      if (op == CPR_OP_FLAGS || (op == CPR_OP_PULL && sel == CPR_SEL_FLAGS))
         flags_d = din[7:0]; // RULE_16
      else if (op == CPR_OP_LDA || op == CPR_OP_TXA)
      begin
         // ALU results never touch the mask, so no unguarded clear
         flags_d = flags_in;
         flags_d[CPR_FB_I] = flags_q[CPR_FB_I]; // RULE_18
      end
      else if (x_unary_op)
      begin
         flags_d[CPR_FB_C] = xu[8];
         flags_d[CPR_FB_N] = xu[7];
         flags_d[CPR_FB_Z] = (xu[7:0] == 8'h00);
      end
      else if (op == CPR_OP_MASK_CLR)
         flags_d[CPR_FB_I] = 1'b0;
      else if (op == CPR_OP_SEI || op == CPR_OP_INT_ENTER)
         flags_d[CPR_FB_I] = 1'b1; // RULE_17
      flags_d = flags_d | CPR_FLAGS_ONES; // RULE_13
   end

   // Accumulator and X carry no reset; ops are ignored while reset is held
   always_ff @(posedge sys_clk)
   begin
      if (rstn)
      begin
         if (op == CPR_OP_LDA || (op == CPR_OP_PULL && sel == CPR_SEL_ACC))
            acc_q <= din[7:0]; // RULE_01
         else if (op == CPR_OP_TXA)
            acc_q <= x_q;
         x_q <= x_d; // RULE_03
      end
   end

   // H register
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         h_q <= CPR_H_RST; // RULE_03
      else if (op == CPR_OP_LDHX || (op == CPR_OP_PULL && sel == CPR_SEL_H))
         h_q <= (op == CPR_OP_LDHX) ? din[15:8] : din[7:0];
   end

   // Program counter, flags and interrupt gate
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         pc_q <= reset_vector; // RULE_12
         flags_q <= CPR_FLAGS_RST;
         inhibit_q <= 1'b0;
         int_allow_q <= 1'b0;
      end
      else
      begin
         pc_q <= pc_d;
         flags_q <= flags_d;
         inhibit_q <= mask_clr ? 1'b1 : (instr_end ? 1'b0 : inhibit_q); // RULE_18
         int_allow_q <= !flags_d[CPR_FB_I] && !mask_clr &&
                        !(inhibit_q && !instr_end); // RULE_18
      end
   end

   // Effective address and memory side; registers never appear on it
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         ea_q <= 16'h0000;
         mem_addr_q <= CPR_VEC_ADDR; // RULE_12
         mem_wdata_q <= 8'h00;
         mem_we_q <= 1'b0;
      end
      else
      begin
         if (op == CPR_OP_DIR)
            ea_q <= {CPR_DIR_PAGE, din[7:0]}; // RULE_15
         else if (op == CPR_OP_IDX)
            ea_q <= hx + din; // RULE_02
         mem_addr_q <= (stk.push || stk.pull) ? stk.addr : ea_q; // RULE_14
         mem_wdata_q <= push_byte; // RULE_09
         mem_we_q <= stk.push; // RULE_09
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_ones;
      flags_q[6:5] == 2'b11;
   endproperty
   a_ones: assert property (p_ones) else $error("Fixed flag bits not one"); // RULE_13

   property p_sp_rst;
      $rose(rstn) |-> sp_q == CPR_SP_RST && h_q == CPR_H_RST;
   endproperty
   a_sp_rst: assert property (p_sp_rst) else $error("Reset values wrong"); // RULE_06

   property p_pc_inc;
      fetch && op == CPR_OP_NOP |=> pc_q == $past(pc_q) + 16'h0001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("PC did not advance"); // RULE_10

   property p_jump;
      op == CPR_OP_JUMP |=> pc_q == $past(din);
   endproperty
   a_jump: assert property (p_jump) else $error("Jump target not loaded"); // RULE_11

   property p_sp_adj;
      op == CPR_OP_SP_ADJ |=> sp_q == $past(sp_q) + {{8{$past(din[7])}}, $past(din[7:0])};
   endproperty
   a_sp_adj: assert property (p_sp_adj) else $error("Stack adjust wrong"); // RULE_07

   property p_sp_low;
      op == CPR_OP_SP_LOW |=> sp_q == {$past(sp_q[15:8]), CPR_SP_RST[7:0]};
   endproperty
   a_sp_low: assert property (p_sp_low) else $error("Low reset touched high byte"); // RULE_08

   sequence s_push;
      op == CPR_OP_PUSH;
   endsequence
   property p_push;
      s_push |=> mem_we_q && mem_addr_q == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001;
   endproperty
   a_push: assert property (p_push) else $error("Push order wrong"); // RULE_19

   property p_int;
      op == CPR_OP_INT_ENTER |=> flags_q[CPR_FB_I] && !int_allow_q;
   endproperty
   a_int: assert property (p_int) else $error("Mask not set on entry"); // RULE_17

   // Mask clear followed by a cycle that is not a boundary
   sequence s_mask_clr_gap;
      op == CPR_OP_MASK_CLR ##1 !instr_end;
   endsequence
   property p_mask_clr;
      s_mask_clr_gap |=> !int_allow_q;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("Interrupt allowed after mask clear"); // RULE_18

   property p_dir;
      op == CPR_OP_DIR |=> ea_q[15:8] == CPR_DIR_PAGE;
   endproperty
   a_dir: assert property (p_dir) else $error("Direct address left page zero"); // RULE_15
endmodule

// file: cpr_regs_tb_top.sv
module cpr_regs_tb_top
   import cpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Register views the monitor can read back
   typedef enum logic [3:0] {K_ACC, K_HX, K_SP, K_PC, K_FLG, K_ONES, K_I, K_EA, K_MADR, K_INT}
      cpr_kind_e;
   // One expected register value
   typedef struct {cpr_kind_e k; logic [15:0] v;} cpr_note_s;
   logic sys_clk = 1'b0; // Bench clock
   logic rstn = 1'b0; // Synchronous reset, active low
   cpr_op_e op; // Operation this cycle
   cpr_sel_e sel; // Push source or pull target
   logic [15:0] din, reset_vector;
   logic [7:0] flags_in;
   logic fetch, instr_end;
   logic [7:0] acc_q, h_q, x_q, flags_q, mem_wdata_q;
   logic [15:0] sp_q, pc_q, ea_q, mem_addr_q;
   logic mem_we_q, int_allow_q;
   int num_errors = 0;
   int cmp_count = 0;
   cpr_note_s notes[$]; // Pending register checks
   logic [23:0] wr_q[$]; // Pending stack writes: address and byte
   cpr_note_s nt;
   // Reference state kept by the driver
   logic [7:0] m_acc, m_x, m_h, m_f;
   logic [15:0] m_sp, m_pc, d;
   logic m_c;
   cpr_op_e xops[9] = '{CPR_OP_CLRX, CPR_OP_INCX, CPR_OP_DECX, CPR_OP_COMX, CPR_OP_ROLX,
                        CPR_OP_NEGX, CPR_OP_RORX, CPR_OP_LSLX, CPR_OP_LSRX};
   cpr_sel_e isel[5] = '{CPR_SEL_PCL, CPR_SEL_PCH, CPR_SEL_X, CPR_SEL_ACC, CPR_SEL_FLAGS};
   logic [7:0] imms[4] = '{8'h80, 8'h80, 8'h90, 8'h05};

   // Free-running clock, 100 ns period
   always #50 sys_clk = ~sys_clk;

   cpr_regs uut (.sys_clk(sys_clk), .rstn(rstn), .op(op), .sel(sel), .din(din),
      .reset_vector(reset_vector), .flags_in(flags_in), .fetch(fetch), .instr_end(instr_end),
      .acc_q(acc_q), .h_q(h_q), .x_q(x_q), .sp_q(sp_q), .pc_q(pc_q), .flags_q(flags_q),
      .ea_q(ea_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q),
      .int_allow_q(int_allow_q));

   // Selects the output view named by a note
   function automatic logic [15:0] got(cpr_kind_e k);
      case (k)
         K_ACC: return {8'h00, acc_q};
         K_HX: return {h_q, x_q};
         K_SP: return sp_q;
         K_PC: return pc_q;
         K_FLG: return {8'h00, flags_q};
         K_ONES: return {14'h0000, flags_q[6:5]};
         K_I: return {15'h0000, flags_q[CPR_FB_I]};
         K_EA: return ea_q;
         K_MADR: return mem_addr_q;
         default: return {15'h0000, int_allow_q};
      endcase
   endfunction

   // Reports one mismatch
   task automatic miss(string m);
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   // Compares a register view
   task automatic cmp_reg(cpr_kind_e k, logic [15:0] e);
      cmp_count++;
      if (got(k) !== e) miss($sformatf("%s got %h exp %h", k.name(), got(k), e));
   endtask

   // Compares a stack write strobe
   task automatic cmp_wr(logic [23:0] e);
      cmp_count++;
      if ({mem_addr_q, mem_wdata_q} !== e) miss($sformatf("write %h exp %h",
         {mem_addr_q, mem_wdata_q}, e));
   endtask

   // Prints counts and the verdict
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Queues an expected register value
   task automatic note(cpr_kind_e k, logic [15:0] v);
      notes.push_back('{k, v});
   endtask

   // Drives one cycle of inputs on the falling edge
   task automatic step(cpr_op_e o, cpr_sel_e s = CPR_SEL_ACC, logic [15:0] dd = 16'h0000,
                       logic f = 1'b0, logic e = 1'b0);
      @(negedge sys_clk);
      op = o;
      sel = s;
      din = dd;
      fetch = f;
      instr_end = e;
   endtask

   // Holds reset for six cycles and checks the reset state
   task automatic do_reset(logic chk_ax);
      @(negedge sys_clk);
      rstn = 1'b0;
      op = CPR_OP_NOP;
      fetch = 1'b0;
      instr_end = 1'b0;
      reset_vector = 16'($urandom);
      repeat (5) @(negedge sys_clk);
      m_sp = CPR_SP_RST;
      m_pc = reset_vector;
      m_h = 8'h00;
      note(K_SP, 16'h00FF);
      note(K_PC, m_pc);
      note(K_FLG, {8'h00, CPR_FLAGS_RST});
      note(K_MADR, 16'hFFFE);
      note(K_INT, 16'h0000);
      if (chk_ax) note(K_HX, {8'h00, m_x});
      if (chk_ax) note(K_ACC, {8'h00, m_acc});
      @(negedge sys_clk);
      rstn = 1'b1;
   endtask

   // Byte expected on the stack for a push source
   function automatic logic [7:0] pval(cpr_sel_e s);
      case (s)
         CPR_SEL_PCL: return m_pc[7:0];
         CPR_SEL_PCH: return m_pc[15:8];
         CPR_SEL_X: return m_x;
         CPR_SEL_ACC: return m_acc;
         default: return m_f;
      endcase
   endfunction

   // Monitor: after each rising edge, takes all pending notes and any write strobe
   always @(posedge sys_clk)
   begin
      #1;
      while (notes.size() > 0)
      begin
         nt = notes.pop_front();
         cmp_reg(nt.k, nt.v);
      end
      if (mem_we_q === 1'b1)
      begin
         if (wr_q.size() == 0) miss("unexpected stack write");
         else cmp_wr(wr_q.pop_front());
      end
   end

   // Cuts a hang short
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miss("run limit reached");
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h0B5094CD));
      op = CPR_OP_NOP;
      sel = CPR_SEL_ACC;
      din = 16'h0000;
      fetch = 1'b0;
      instr_end = 1'b0;
      flags_in = 8'h00;
      reset_vector = 16'h0000;
      do_reset(1'b0);
      // Loads and index pair
      m_acc = 8'($urandom);
      flags_in = 8'($urandom);
      step(CPR_OP_LDA, CPR_SEL_ACC, {8'h00, m_acc});
      note(K_ACC, {8'h00, m_acc});
      note(K_ONES, 16'h0003);
      note(K_I, 16'h0001);
      d = 16'($urandom);
      step(CPR_OP_LDHX, CPR_SEL_ACC, d);
      {m_h, m_x} = d;
      note(K_HX, d);
      d = 16'($urandom) | 16'hA500;
      step(CPR_OP_IDX, CPR_SEL_ACC, d);
      note(K_EA, {m_h, m_x} + d);
      step(CPR_OP_DIR, CPR_SEL_ACC, d);
      note(K_EA, {CPR_DIR_PAGE, d[7:0]});
      // Unary operations on the low index byte, carry tracked from COMX on
      m_x = 8'($urandom);
      step(CPR_OP_LDX, CPR_SEL_ACC, {8'h00, m_x});
      for (int i = 0; i < 9; i++)
      begin
         step(xops[i]);
         case (xops[i])
            CPR_OP_CLRX: m_x = 8'h00;
            CPR_OP_INCX: m_x = m_x + 8'h01;
            CPR_OP_DECX: m_x = m_x - 8'h01;
            CPR_OP_COMX: {m_c, m_x} = {1'b1, ~m_x};
            CPR_OP_ROLX: {m_c, m_x} = {m_x, m_c};
            CPR_OP_NEGX: {m_c, m_x} = {m_x != 8'h00, 8'h00 - m_x};
            CPR_OP_RORX: {m_x, m_c} = {m_c, m_x};
            CPR_OP_LSLX: {m_c, m_x} = {m_x, 1'b0};
            default: {m_x, m_c} = {1'b0, m_x};
         endcase
         note(K_HX, {m_h, m_x});
      end
      step(CPR_OP_TXA);
      m_acc = m_x;
      note(K_ACC, {8'h00, m_acc});
      m_acc = 8'($urandom);
      step(CPR_OP_LDA, CPR_SEL_ACC, {8'h00, m_acc});
      step(CPR_OP_TAX);
      m_x = m_acc;
      note(K_HX, {m_h, m_x});
      // Stack adjust, crossing the high byte, then low-byte reset
      for (int i = 0; i < 4; i++)
      begin
         step(CPR_OP_SP_ADJ, CPR_SEL_ACC, {8'h00, imms[i]});
         m_sp = m_sp + {{8{imms[i][7]}}, imms[i]};
         note(K_SP, m_sp);
      end
      step(CPR_OP_SP_LOW);
      m_sp[7:0] = 8'hFF;
      note(K_SP, m_sp);
      // Mask clear holds off interrupts until the next boundary
      step(CPR_OP_MASK_CLR);
      note(K_I, 16'h0000);
      note(K_INT, 16'h0000);
      step(CPR_OP_NOP);
      note(K_INT, 16'h0000);
      step(CPR_OP_NOP, CPR_SEL_ACC, 16'h0000, 1'b0, 1'b1);
      note(K_INT, 16'h0001);
      step(CPR_OP_SEI);
      note(K_I, 16'h0001);
      note(K_INT, 16'h0000);
      // Flags write clearing the set mask, then interrupt entry
      m_f = 8'($urandom) & 8'hF7;
      step(CPR_OP_FLAGS, CPR_SEL_ACC, {8'h00, m_f});
      m_f = m_f | CPR_FLAGS_ONES;
      note(K_FLG, {8'h00, m_f});
      note(K_INT, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         step(CPR_OP_PUSH, isel[i]);
         wr_q.push_back({m_sp, pval(isel[i])});
         m_sp = m_sp - 16'h0001;
         note(K_SP, m_sp);
      end
      d = 16'($urandom);
      step(CPR_OP_INT_ENTER, CPR_SEL_ACC, d);
      m_pc = d;
      note(K_PC, m_pc);
      note(K_I, 16'h0001);
      // Back-to-back pulls
      d = 16'($urandom);
      step(CPR_OP_PULL, CPR_SEL_ACC, d);
      m_sp = m_sp + 16'h0001;
      m_acc = d[7:0];
      note(K_ACC, {8'h00, m_acc});
      step(CPR_OP_PULL, CPR_SEL_X, ~d);
      m_sp = m_sp + 16'h0001;
      m_x = ~d[7:0];
      note(K_HX, {m_h, m_x});
      note(K_SP, m_sp);
      note(K_MADR, m_sp);
      // Pulls into the high index byte and the program counter halves
      step(CPR_OP_PULL, CPR_SEL_H, d);
      m_h = d[7:0];
      note(K_HX, {m_h, m_x});
      step(CPR_OP_PULL, CPR_SEL_PCH, d);
      step(CPR_OP_PULL, CPR_SEL_PCL, ~d);
      m_sp = m_sp + 16'h0003;
      m_pc = {d[7:0], ~d[7:0]};
      note(K_PC, m_pc);
      note(K_SP, m_sp);
      // Sequential fetches, then change-of-flow beating a fetch
      repeat ($urandom_range(3, 9))
      begin
         step(CPR_OP_NOP, CPR_SEL_ACC, 16'h0000, 1'b1);
         m_pc = m_pc + 16'h0001;
         note(K_PC, m_pc);
      end
      d = 16'($urandom);
      step(CPR_OP_JUMP, CPR_SEL_ACC, d, 1'b1);
      m_pc = d;
      note(K_PC, m_pc);
      d = 16'h00F0;
      step(CPR_OP_BRANCH, CPR_SEL_ACC, d);
      m_pc = m_pc + 16'hFFF0;
      note(K_PC, m_pc);
      // Second reset keeps accumulator and low index byte
      do_reset(1'b1);
      step(CPR_OP_NOP, CPR_SEL_ACC, 16'h0000, 1'b1);
      note(K_PC, m_pc + 16'h0001);
      step(CPR_OP_NOP);
      repeat (3) @(negedge sys_clk);
      if (notes.size() != 0 || wr_q.size() != 0) miss("expected results left over");
      tally_and_finish();
   end
endmodule
